// *** include/scm_pkg.sv ***
// Purpose: Shared constants and types for the serializer clock mode select block
// Assumes: 8-bit register port, 40 MHz core clock
// Notes:   Mode codes, register offsets and reset values live here
package scm_pkg;

   // Mode field encodings
   localparam logic [2:0] SCM_MODE_SYNC   = 3'h0;
   localparam logic [2:0] SCM_MODE_EXT    = 3'h2;
   localparam logic [2:0] SCM_MODE_INT    = 3'h3;
   localparam logic [2:0] SCM_MODE_LEGACY = 3'h5;

   // Register offsets
   localparam logic [7:0] SCM_ADDR_MODE   = 8'h03;
   localparam logic [7:0] SCM_ADDR_LFMT   = 8'h04;
   localparam logic [7:0] SCM_ADDR_OSC    = 8'h05;
   localparam logic [7:0] SCM_ADDR_PDIV   = 8'h06;
   localparam logic [7:0] SCM_ADDR_MNUM   = 8'h07;
   localparam logic [7:0] SCM_ADDR_NDEN   = 8'h08;
   localparam logic [7:0] SCM_ADDR_STAT   = 8'h09;
   localparam logic [7:0] SCM_ADDR_LCFG   = 8'h10;
   localparam logic [7:0] SCM_ADDR_LDT    = 8'h11;

   // Field positions
   localparam int SCM_BIT_OVR_EN    = 4;
   localparam int SCM_BIT_OSC_SEL   = 3;
   localparam int SCM_BIT_MATCH_EN  = 7;
   localparam int SCM_BIT_FORCE_EN  = 0;
   localparam int SCM_BIT_FORCE_12  = 1;
   localparam int SCM_BIT_LONG_EN   = 0;
   localparam int SCM_BIT_YUV_EN    = 1;

   // Values after reset
   localparam logic [7:0] SCM_RST_PDIV = 8'h04;
   localparam logic [7:0] SCM_RST_MNUM = 8'h01;
   localparam logic [7:0] SCM_RST_NDEN = 8'h01;
   localparam logic [7:0] SCM_RST_OSC  = 8'h08;

   // Divider codes and multipliers
   localparam logic [2:0]  SCM_DIV_BY1    = 3'h0;
   localparam logic [2:0]  SCM_DIV_BY2    = 3'h1;
   localparam logic [7:0]  SCM_MULT_SYNC  = 8'ha0;
   localparam logic [7:0]  SCM_MULT_EXT1  = 8'h50;
   localparam logic [7:0]  SCM_MULT_EXT2  = 8'h28;
   localparam logic [7:0]  SCM_MULT_INT   = 8'h50;
   localparam logic [7:0]  SCM_MULT_LEG   = 8'h1c;

   // Bandwidth caps in Mbps
   localparam logic [11:0] SCM_CSI_FULL   = 12'h9e0;
   localparam logic [11:0] SCM_CSI_HALF   = 12'h4f0;

   // Packet data types
   localparam logic [5:0]  SCM_DT_RAW10   = 6'h2b;
   localparam logic [5:0]  SCM_DT_RAW12   = 6'h2c;
   localparam logic [5:0]  SCM_DT_YUV422  = 6'h1e;
   localparam logic [5:0]  SCM_DT_LONG_LO = 6'h10;

   typedef enum logic [2:0] {
      SCM_REF_BACK = 3'b001,
      SCM_REF_EXT  = 3'b010,
      SCM_REF_OSC  = 3'b100
   } scm_ref_t;

   typedef struct packed {
      scm_ref_t    ref_src;
      logic [7:0]  fc_mult;
      logic        clk_out_en;
      logic        local_osc_needed;
      logic        ext_clk_needed;
      logic [11:0] csi_cap_mbps;
   } scm_clk_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } scm_bus_t;

endpackage : scm_pkg

// *** logic/scm_clock_mode_select.sv ***
// Purpose: Clock mode selection and reference derivation for a link serializer
// Assumes: Strap code already digitised to three bits; pins arrive asynchronously
// Notes:   Rates are reported as multipliers of the selected reference
`timescale 1ns/100ps
`default_nettype none

// Function
// - Strapped mode becomes default at power-up
// - Active mode picks forward-channel reference source
// - Sync mode: back-channel clock, rate f x 160
// - Sync mode needs no local oscillator
// - External mode: x80 at b000, x40 at b001
// - Internal mode uses only always-on oscillator
// - Mode field always reports active mode
// - Override bit clear: mode field read-only
// - Strap latched on power-down pin rising edge
// - Override bit set: mode field writable
// - Format override forces legacy raw10 or raw12
// - Data-type filter passes matching type when enabled
// - Legacy config selects long and YUV handling
// - Mode codes 0, 2, 3, 5
module scm_clock_mode_select (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // Register port
   input  wire scm_pkg::scm_bus_t     bus_i,
   output logic [7:0]                 rdata_o,
   // Pins
   input  wire logic [2:0]            mode_strap_i,
   input  wire logic                  powerdown_n_pin_i,
   input  wire logic                  ext_ref_active_i,
   // Back-channel recovery status
   input  wire logic                  bc_clk_lock_i,
   input  wire logic                  bc_half_rate_i,
   // Packet type check
   input  wire logic                  pkt_valid_i,
   input  wire logic [5:0]            pkt_dt_i,
   output logic                       pkt_pass_o,
   // Clock configuration
   output scm_pkg::scm_clk_cfg_t      clk_cfg_o,
   output logic [2:0]                 mode_o,
   output logic                       ref_valid_o,
   output logic [15:0]                clk_out_num_o,
   output logic [15:0]                clk_out_den_o,
   output logic                       legacy_raw12_o
);

   function automatic logic [7:0] fc_mult_of(input logic [2:0] mode, input logic [2:0] div);
      logic [7:0] m;
      case (mode)
         scm_pkg::SCM_MODE_SYNC:   m = scm_pkg::SCM_MULT_SYNC;
         scm_pkg::SCM_MODE_EXT:    m = (div == scm_pkg::SCM_DIV_BY2) ?
                                       scm_pkg::SCM_MULT_EXT2 : scm_pkg::SCM_MULT_EXT1;
         scm_pkg::SCM_MODE_INT:    m = scm_pkg::SCM_MULT_INT;
         scm_pkg::SCM_MODE_LEGACY: m = scm_pkg::SCM_MULT_LEG;
         default:                  m = scm_pkg::SCM_MULT_SYNC;
      endcase
      return m;
   endfunction : fc_mult_of

   function automatic logic wr_hit(input scm_pkg::scm_bus_t b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction : wr_hit

   // Pin synchronisers
   logic [2:0] pdn_s_q;
   logic [2:0] ext_s_q;
   logic [2:0] strap_s1_q;
   logic [2:0] strap_s2_q;
   logic [2:0] strap_s3_q;
   logic       pdn_lvl_q;
   logic       ext_lvl_q;
   logic [2:0] strap_lvl_q;
   logic       pdn_rise;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pdn_s_q    <= 3'h0;
         ext_s_q    <= 3'h0;
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
         strap_s3_q <= 3'h0;
      end
      else
      begin
         pdn_s_q    <= {pdn_s_q[1:0], powerdown_n_pin_i};
         ext_s_q    <= {ext_s_q[1:0], ext_ref_active_i};
         strap_s1_q <= mode_strap_i;
         strap_s2_q <= strap_s1_q;
         strap_s3_q <= strap_s2_q;
      end
   end

   // Levels accepted once second and third stages agree
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pdn_lvl_q   <= 1'b0;
         ext_lvl_q   <= 1'b0;
         strap_lvl_q <= 3'h0;
      end
      else
      begin
         if (pdn_s_q[1] == pdn_s_q[2])
            pdn_lvl_q <= pdn_s_q[2];
         if (ext_s_q[1] == ext_s_q[2])
            ext_lvl_q <= ext_s_q[2];
         if (strap_s2_q == strap_s3_q)
            strap_lvl_q <= strap_s3_q;
      end
   end

   assign pdn_rise = pdn_s_q[1] && pdn_s_q[2] && !pdn_lvl_q;

   // Mode register
   logic [2:0] mode_q;
   logic       ovr_en_q;
   logic       mode_wr;
   assign mode_wr = wr_hit(bus_i, scm_pkg::SCM_ADDR_MODE);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ovr_en_q <= 1'b0;
      else if (mode_wr)
         ovr_en_q <= bus_i.wdata[scm_pkg::SCM_BIT_OVR_EN];
   end

   // Strap latch outranks a software write in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode_q <= scm_pkg::SCM_MODE_SYNC;
      else if (pdn_rise)
         mode_q <= strap_lvl_q;
      else if (mode_wr && bus_i.wdata[scm_pkg::SCM_BIT_OVR_EN])
         mode_q <= bus_i.wdata[2:0];
   end

   // Other software registers
   logic [7:0] lfmt_q;
   logic [7:0] osc_q;
   logic [7:0] pdiv_q;
   logic [7:0] mnum_q;
   logic [7:0] nden_q;
   logic [7:0] lcfg_q;
   logic [7:0] ldt_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lfmt_q <= 8'h00;
         osc_q  <= scm_pkg::SCM_RST_OSC;
         pdiv_q <= scm_pkg::SCM_RST_PDIV;
         mnum_q <= scm_pkg::SCM_RST_MNUM;
         nden_q <= scm_pkg::SCM_RST_NDEN;
         lcfg_q <= 8'h00;
         ldt_q  <= 8'h00;
      end
      else
      begin
         if (wr_hit(bus_i, scm_pkg::SCM_ADDR_LFMT))
            lfmt_q <= bus_i.wdata;
         if (wr_hit(bus_i, scm_pkg::SCM_ADDR_OSC))
            osc_q <= {4'h0, bus_i.wdata[3:0]};
         if (wr_hit(bus_i, scm_pkg::SCM_ADDR_PDIV))
            pdiv_q <= bus_i.wdata;
         if (wr_hit(bus_i, scm_pkg::SCM_ADDR_MNUM))
            mnum_q <= bus_i.wdata;
         if (wr_hit(bus_i, scm_pkg::SCM_ADDR_NDEN))
            nden_q <= bus_i.wdata;
         if (wr_hit(bus_i, scm_pkg::SCM_ADDR_LCFG))
            lcfg_q <= bus_i.wdata;
         if (wr_hit(bus_i, scm_pkg::SCM_ADDR_LDT))
            ldt_q <= bus_i.wdata;
      end
   end

   // Clock configuration derived from the active mode
   scm_pkg::scm_clk_cfg_t cfg_d;
   scm_pkg::scm_clk_cfg_t cfg_q;
   logic                  ref_valid_q;
   logic                  osc_full;
   assign osc_full = osc_q[scm_pkg::SCM_BIT_OSC_SEL];
   always_comb
   begin
      cfg_d                  = '0;
      cfg_d.fc_mult          = fc_mult_of(mode_q, osc_q[2:0]);
      cfg_d.clk_out_en       = 1'b1;
      cfg_d.csi_cap_mbps     = scm_pkg::SCM_CSI_FULL;
      case (mode_q)
         scm_pkg::SCM_MODE_SYNC:
         begin
            cfg_d.ref_src          = scm_pkg::SCM_REF_BACK;
            cfg_d.local_osc_needed = 1'b0;
            cfg_d.csi_cap_mbps     = bc_half_rate_i ?
                                     scm_pkg::SCM_CSI_HALF : scm_pkg::SCM_CSI_FULL;
         end
         scm_pkg::SCM_MODE_INT:
         begin
            cfg_d.ref_src          = scm_pkg::SCM_REF_OSC;
            cfg_d.clk_out_en       = 1'b0;
            cfg_d.csi_cap_mbps     = osc_full ?
                                     scm_pkg::SCM_CSI_FULL : scm_pkg::SCM_CSI_HALF;
         end
         scm_pkg::SCM_MODE_EXT, scm_pkg::SCM_MODE_LEGACY:
         begin
            cfg_d.ref_src          = scm_pkg::SCM_REF_EXT;
            cfg_d.local_osc_needed = 1'b1;
            cfg_d.ext_clk_needed   = 1'b1;
         end
         default: cfg_d.ref_src = scm_pkg::SCM_REF_BACK;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_q       <= '0;
         ref_valid_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         case (cfg_d.ref_src)
            scm_pkg::SCM_REF_BACK: ref_valid_q <= bc_clk_lock_i;
            scm_pkg::SCM_REF_EXT:  ref_valid_q <= ext_lvl_q;
            scm_pkg::SCM_REF_OSC:  ref_valid_q <= 1'b1;
            default:               ref_valid_q <= 1'b0;
         endcase
      end
   end

   // Sensor clock ratio: f x num / den
   logic [15:0] num_q;
   logic [15:0] den_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         num_q <= 16'h0000;
         den_q <= 16'h0000;
      end
      else
      begin
         num_q <= cfg_d.clk_out_en ? ({8'h00, cfg_d.fc_mult} * {8'h00, mnum_q}) : 16'h0000;
         den_q <= {8'h00, pdiv_q} * {8'h00, nden_q};
      end
   end

   // Legacy packet filter
   logic raw12_sel;
   logic pass_d;
   logic pass_q;
   assign raw12_sel = lfmt_q[scm_pkg::SCM_BIT_FORCE_EN] && lfmt_q[scm_pkg::SCM_BIT_FORCE_12];
   always_comb
   begin
      pass_d = 1'b0;
      if (pkt_valid_i && (mode_q == scm_pkg::SCM_MODE_LEGACY))
      begin
         if (pkt_dt_i == (raw12_sel ? scm_pkg::SCM_DT_RAW12 : scm_pkg::SCM_DT_RAW10))
            pass_d = 1'b1;
         if (ldt_q[scm_pkg::SCM_BIT_MATCH_EN] && (pkt_dt_i == ldt_q[5:0]))
            pass_d = 1'b1;
         if (lcfg_q[scm_pkg::SCM_BIT_YUV_EN] && (pkt_dt_i == scm_pkg::SCM_DT_YUV422))
            pass_d = 1'b1;
         if (lcfg_q[scm_pkg::SCM_BIT_LONG_EN] && (pkt_dt_i >= scm_pkg::SCM_DT_LONG_LO))
            pass_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pass_q <= 1'b0;
      else
         pass_q <= pass_d;
   end

   // Read port, data one cycle after the strobe
   logic [7:0] rdata_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdata_q <= 8'h00;
      else if (bus_i.rd)
      begin
         case (bus_i.addr)
            scm_pkg::SCM_ADDR_MODE: rdata_q <= {3'h0, ovr_en_q, 1'b0, mode_q};
            scm_pkg::SCM_ADDR_LFMT: rdata_q <= lfmt_q;
            scm_pkg::SCM_ADDR_OSC:  rdata_q <= osc_q;
            scm_pkg::SCM_ADDR_PDIV: rdata_q <= pdiv_q;
            scm_pkg::SCM_ADDR_MNUM: rdata_q <= mnum_q;
            scm_pkg::SCM_ADDR_NDEN: rdata_q <= nden_q;
            scm_pkg::SCM_ADDR_STAT: rdata_q <= {2'h0, strap_lvl_q, ext_lvl_q, pdn_lvl_q,
                                                ref_valid_q};
            scm_pkg::SCM_ADDR_LCFG: rdata_q <= lcfg_q;
            scm_pkg::SCM_ADDR_LDT:  rdata_q <= ldt_q;
            default:                rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   assign rdata_o        = rdata_q;
   assign clk_cfg_o      = cfg_q;
   assign mode_o         = mode_q;
   assign ref_valid_o    = ref_valid_q;
   assign clk_out_num_o  = num_q;
   assign clk_out_den_o  = den_q;
   assign pkt_pass_o     = pass_q;
   assign legacy_raw12_o = raw12_sel;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_pdn_rise;
      !pdn_lvl_q && pdn_s_q[1] && pdn_s_q[2];
   endsequence
   sequence s_locked_write;
      mode_wr && !bus_i.wdata[scm_pkg::SCM_BIT_OVR_EN] && !pdn_rise;
   endsequence
   // Skip the edge of reset release: cfg_q is still cleared there
   a_sync_ref_rate: assert property (
      !$past(rst_i) && mode_q == scm_pkg::SCM_MODE_SYNC |=>
         clk_cfg_o.ref_src == scm_pkg::SCM_REF_BACK && clk_cfg_o.fc_mult == 8'ha0)
      else $error("sync mode reference or rate wrong");
   a_sync_no_osc: assert property (
      mode_q == scm_pkg::SCM_MODE_SYNC |=> !clk_cfg_o.local_osc_needed)
      else $error("sync mode asks for local oscillator");
   a_ext_div_rate: assert property (
      mode_q == scm_pkg::SCM_MODE_EXT && osc_q[2:0] == 3'h1 |=> clk_cfg_o.fc_mult == 8'h28)
      else $error("external divide-by-two rate wrong");
   a_ext_full_rate: assert property (
      mode_q == scm_pkg::SCM_MODE_EXT && osc_q[2:0] == 3'h0 |=>
         clk_cfg_o.fc_mult == 8'h50 && clk_cfg_o.ref_src == scm_pkg::SCM_REF_EXT)
      else $error("external rate wrong");
   a_int_osc_only: assert property (
      mode_q == scm_pkg::SCM_MODE_INT |=>
         clk_cfg_o.ref_src == scm_pkg::SCM_REF_OSC && ref_valid_o && clk_out_num_o == 16'h0000)
      else $error("internal mode not on oscillator");
   a_strap_latch: assert property (
      s_pdn_rise |=> mode_o == $past(strap_lvl_q) ##1 pdn_lvl_q)
      else $error("strap not latched on power-down release");
   a_mode_locked: assert property (
      s_locked_write |=> $stable(mode_o))
      else $error("mode changed while read-only");
   a_mode_override: assert property (
      mode_wr && bus_i.wdata[scm_pkg::SCM_BIT_OVR_EN] && !pdn_rise |=>
         mode_o == $past(bus_i.wdata[2:0]))
      else $error("override write not taken");
   a_mode_readback: assert property (
      bus_i.rd && bus_i.addr == 8'h03 |=> rdata_o[2:0] == $past(mode_q))
      else $error("mode field readback wrong");
   a_half_rate_cap: assert property (
      mode_q == scm_pkg::SCM_MODE_INT && !osc_full |=> clk_cfg_o.csi_cap_mbps == 12'h4f0)
      else $error("half-rate cap wrong");
endmodule : scm_clock_mode_select

`default_nettype wire

// *** dv/scm_far_model.sv ***
// Purpose: Far side of the link: companion deserializer back channel and board clock
// Assumes: Back-channel lock comes LOCK_DLY cycles after the channel is switched on
// Notes:   A larger LOCK_DLY models a slowly training deserializer
`timescale 1ns/100ps
`default_nettype none
module scm_far_model #(
   parameter int LOCK_DLY = 3
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Bench controls
   input  wire logic bc_on_i,
   input  wire logic half_i,
   input  wire logic ext_run_i,
   // Towards the serializer
   output logic      bc_clk_lock_o,
   output logic      bc_half_rate_o,
   output logic      ext_ref_active_o
);
   int cnt_q;

   // Lock only after the back channel has trained
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !bc_on_i)
         cnt_q <= 0;
      else if (cnt_q < LOCK_DLY)
         cnt_q <= cnt_q + 1;
   end

   assign bc_clk_lock_o    = (cnt_q == LOCK_DLY);
   assign bc_half_rate_o   = half_i & bc_clk_lock_o;
   assign ext_ref_active_o = ext_run_i;
endmodule : scm_far_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the clock mode select block
// Assumes: Far side from scm_far_model; integer register model kept in the bench
// Notes:   Packet filter settings and data types are drawn at random
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                  clk_i = 1'b0;
   logic                  rst_i = 1'b1;
   scm_pkg::scm_bus_t     bus;
   scm_pkg::scm_clk_cfg_t cfg;
   logic [2:0]            strap;
   logic [2:0]            mode;
   logic                  pdn_n;
   logic                  bc_on;
   logic                  half;
   logic                  ext_run;
   logic                  lock;
   logic                  hrate;
   logic                  ext_act;
   logic                  pkt_valid;
   logic [5:0]            pkt_dt;
   logic                  pkt_pass;
   logic [7:0]            rdata;
   logic                  ref_valid;
   logic                  raw12;
   logic [15:0]           num;
   logic [15:0]           den;
   int                    regm[256];
   int                    mode_m = 0;
   int                    ovr_m = 0;
   int                    miscompares = 0;
   int                    samples_checked = 0;
   int                    seed = 79109;
   logic [7:0]            raddr[9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                       8'h10, 8'h11, 8'h20};
   logic [2:0]            modes[4] = '{3'h2, 3'h3, 3'h5, 3'h0};
   logic [5:0]            dts[6] = '{6'h2b, 6'h2c, 6'h1e, 6'h10, 6'h0f, 6'h3f};

   always #12.5 clk_i = ~clk_i;

   scm_clock_mode_select dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
      .mode_strap_i(strap), .powerdown_n_pin_i(pdn_n), .ext_ref_active_i(ext_act),
      .bc_clk_lock_i(lock), .bc_half_rate_i(hrate), .pkt_valid_i(pkt_valid),
      .pkt_dt_i(pkt_dt), .pkt_pass_o(pkt_pass), .clk_cfg_o(cfg), .mode_o(mode),
      .ref_valid_o(ref_valid), .clk_out_num_o(num), .clk_out_den_o(den),
      .legacy_raw12_o(raw12));

   scm_far_model far_u (
      .clk_i(clk_i), .rst_i(rst_i), .bc_on_i(bc_on), .half_i(half),
      .ext_run_i(ext_run), .bc_clk_lock_o(lock), .bc_half_rate_o(hrate),
      .ext_ref_active_o(ext_act));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string name, input int exp, input logic [15:0] got);
      samples_checked++;
      if (got !== 16'(exp))
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, 16'(exp), got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      bus <= '0;
      if (a == 8'h03)
         ovr_m = d[4];
      if (a == 8'h03 && d[4])
         mode_m = d[2:0];
      if (a inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11})
         regm[a] = d;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int e;
      e = (a == 8'h03) ? ovr_m * 16 + mode_m : regm[a];
      @(posedge clk_i);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      bus <= '0;
      #1 chk("rdata", e, rdata);
   endtask : rd

   task automatic chk_cfg();
      int mult;
      int refs;
      int cap;
      // Expectations taken after the settle time, once new inputs stand
      repeat (6) @(posedge clk_i);
      mult = (mode_m == 2) ? ((regm[5][2:0] == 1) ? 'h28 : 'h50) :
             (mode_m == 3) ? 'h50 : (mode_m == 5) ? 'h1c : 'ha0;
      refs = (mode_m == 3) ? 4 : (mode_m == 2 || mode_m == 5) ? 2 : 1;
      cap  = ((mode_m == 0 && half) || (mode_m == 3 && !regm[5][3])) ? 'h4f0 : 'h9e0;
      #1 chk("mode", mode_m, mode);
      chk("ref_src", refs, cfg.ref_src);
      chk("fc_mult", mult, cfg.fc_mult);
      chk("csi_cap", cap, cfg.csi_cap_mbps);
      chk("clk_out_en", mode_m != 3, cfg.clk_out_en);
      chk("ext_need", mode_m == 2 || mode_m == 5, cfg.ext_clk_needed);
      chk("num", (mode_m == 3) ? 0 : mult * regm[7], num);
      chk("den", regm[6] * regm[8], den);
      chk("ref_valid", (mode_m == 3) ? 1 : (mode_m == 0) ? bc_on : ext_run, ref_valid);
      if (mode_m == 0)
         chk("osc_need", 0, cfg.local_osc_needed);
   endtask : chk_cfg

   task automatic latch(input logic [2:0] s);
      @(posedge clk_i);
      strap <= s;
      pdn_n <= 1'b0;
      repeat (5) @(posedge clk_i);
      pdn_n <= 1'b1;
      mode_m = s;
      for (int n = 0; n < 10 && mode !== s; n++)
         @(posedge clk_i);
      if (mode !== s)
      begin
         miscompares++;
         $display("BAD mode_wait expected %h seen %h", s, mode);
         wrap_up();
      end
   endtask : latch

   task automatic pkt(input logic [5:0] dt);
      logic e;
      e = mode_m == 5 && (dt == ((regm[4] == 3) ? 6'h2c : 6'h2b) ||
          (regm['h11][7] && dt == regm['h11][5:0]) || (regm['h10][1] && dt == 6'h1e) ||
          (regm['h10][0] && dt >= 6'h10));
      @(posedge clk_i);
      pkt_valid <= 1'b1;
      pkt_dt <= dt;
      @(posedge clk_i);
      pkt_valid <= 1'b0;
      #1 chk("pkt_pass", e, pkt_pass);
      chk("raw12", regm[4] == 3, raw12);
   endtask : pkt

   initial
   begin
      bus = '0;
      strap = 3'h0;
      pdn_n = 1'b0;
      bc_on = 1'b1;
      half = 1'b0;
      ext_run = 1'b1;
      pkt_valid = 1'b0;
      pkt_dt = 6'h00;
      regm = '{default: 0};
      regm[5] = 8;
      regm[6] = 4;
      regm[7] = 1;
      regm[8] = 1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (raddr[i])
         rd(raddr[i]);
      chk_cfg();
      $display("test reset done");
      wr(8'h06, 8'h08);
      wr(8'h07, 8'h03);
      wr(8'h08, 8'h05);
      foreach (modes[i])
      begin
         latch(modes[i]);
         chk_cfg();
         rd(8'h03);
         pkt(6'h2b);
      end
      $display("test strap done");
      wr(8'h03, 8'h05);
      chk_cfg();
      wr(8'h03, 8'h15);
      chk_cfg();
      rd(8'h03);
      wr(8'h03, 8'h13);
      wr(8'h05, 8'h00);
      chk_cfg();
      wr(8'h05, 8'h08);
      $display("test override done");
      wr(8'h03, 8'h15);
      for (int k = 0; k < 24; k++)
      begin
         wr(8'h04, 8'($random(seed) & 3));
         wr(8'h10, 8'($random(seed) & 3));
         wr(8'h11, 8'($random(seed) & 8'hbf));
         pkt(k[0] ? regm['h11][5:0] : dts[{$random(seed)} % 6]);
      end
      $display("test packet done");
      latch(3'h0);
      half <= 1'b1;
      chk_cfg();
      @(posedge clk_i) half <= 1'b0;
      bc_on <= 1'b0;
      chk_cfg();
      @(posedge clk_i) bc_on <= 1'b1;
      chk_cfg();
      latch(3'h2);
      wr(8'h05, 8'h09);
      chk_cfg();
      @(posedge clk_i) ext_run <= 1'b0;
      chk_cfg();
      @(posedge clk_i) ext_run <= 1'b1;
      wr(8'h06, 8'h10);
      chk_cfg();
      regm[9] = strap * 8 + ext_run * 4 + pdn_n * 2 + 1;
      rd(8'h09);
      $display("test clock source done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
